// file: core/card_pm_event_gating.sv
`timescale 1ns/1ps
`default_nettype none
// How it works
// - Status bank is bypassed by default; wake then acts as in PCI mode on status pin.
// - Four 32-bit bank registers respond only while the bank enable input is high.
// - Bank on: irq pin asserts only if irq mask set and irq flag latched.
// - Bank on: status pin asserts only if both wake masks and general wake flag set.
// - Bank gating acts on top of requests already gated by local configuration.
// - Bank on: writing enable one sets both wake mask bits 4 and 14.
// - Writing enable zero clears both wake mask bits, idling the status pin.
// - While enable is set, every wake event latches status and general wake flag.
// - Clearing wake mask bits never touches the enable bit.
// - Writing one to the status bit also clears the general wake flag.
// - Writing one to the general wake flag clears it and the status bit.
// - Event register wake flag bit 4, irq flag bit 15, each write-one-to-clear.
// - Event register bits 0 to 3 read zero; other unlisted bits reserved, zero.
// - Reset clears enable, masks, wake flag, status pin and status bit.
// - Status bit at bit 15 is sticky, cleared by writing one.
// - Wake events are raised only while enable bit 8 is set.
module card_pm_event_gating
    import card_pm_pkg::*;
(
    // Clock and reset
    input wire logic mclk,
    input wire logic rst,
    // Local configuration and conditioned internal requests
    input wire logic bank_enable,
    input wire logic wake_request,
    input wire logic powerdown_request,
    // Power management control/status register write port
    input wire logic pm_control_status_write,
    input wire logic [pm_control_status_width-1:0] pm_control_status_wdata,
    // Status bank register port
    input wire logic reg_write,
    input wire logic reg_read,
    input wire logic [3:0] reg_addr,
    input wire logic [reg_width-1:0] reg_wdata,
    output logic [reg_width-1:0] reg_rdata,
    // Power management state
    output logic pm_event_enable,
    output logic pm_event_status,
    // Card pins
    output logic card_irq_pin_n,
    output logic card_status_change_pin
);

    // -------------------------------------------------------------------
    // State
    // -------------------------------------------------------------------
    logic general_wake_flag;
    logic irq_request_flag;
    logic general_wake_mask;
    logic wake_mask_flag;
    logic irq_mask;
    logic next_pm_event_enable;
    logic next_pm_event_status;
    logic next_general_wake_flag;
    logic next_irq_request_flag;
    logic next_general_wake_mask;
    logic next_wake_mask_flag;
    logic next_irq_mask;
    logic next_card_irq_pin_n;
    logic next_card_status_change_pin;
    logic [reg_width-1:0] next_reg_rdata;

    // -------------------------------------------------------------------
    // Access decode
    // -------------------------------------------------------------------
    // Decoded bank strobes; accesses are dead while bypassed
    logic wr_event;
    logic wr_mask;
    logic wr_force;
    logic rd_bank;
    logic wake_event;

    // The bank keeps its contents while bypassed; software that turns the
    // bank back on sees whatever was latched or masked before, not a reset
    assign wr_event = reg_write && bank_enable && (reg_addr == event_latch_off);
    assign wr_mask = reg_write && bank_enable && (reg_addr == event_mask_off);
    assign wr_force = reg_write && bank_enable && (reg_addr == force_event_off);
    assign rd_bank = reg_read && bank_enable;

    // A wake request only counts as an event while the enable is set
    assign wake_event = wake_request && pm_event_enable;

    // -------------------------------------------------------------------
    // Write decode
    // -------------------------------------------------------------------
    logic enable_write_one;
    logic enable_write_zero;
    logic status_w1c;
    logic event_wake_w1c;
    logic event_irq_w1c;
    logic force_wake;
    logic force_irq;

    // Enable write split into its two effects on the wake masks
    assign enable_write_one = pm_control_status_write && pm_control_status_wdata[pm_enable_bit];
    assign enable_write_zero = pm_control_status_write && !pm_control_status_wdata[pm_enable_bit];

    // Write-one-to-clear strobes; a written zero leaves the flag alone
    assign status_w1c = pm_control_status_write && pm_control_status_wdata[pm_status_bit];
    assign event_wake_w1c = wr_event && reg_wdata[general_wake_bit];
    assign event_irq_w1c = wr_event && reg_wdata[irq_request_bit];

    // Force writes only set; a written zero never clears a latch
    assign force_wake = wr_force && reg_wdata[general_wake_bit];
    assign force_irq = wr_force && reg_wdata[irq_request_bit];

    // -------------------------------------------------------------------
    // Enable and mask group
    // -------------------------------------------------------------------
    // The enable write is applied after a same-cycle mask write, so the
    // coupling to the enable wins; mask writes never reach the enable
    always_comb begin
        next_pm_event_enable = pm_event_enable;
        next_general_wake_mask = general_wake_mask;
        next_wake_mask_flag = wake_mask_flag;
        next_irq_mask = irq_mask;

        // Plain mask register write
        if (wr_mask) begin
            next_general_wake_mask = reg_wdata[general_wake_bit];
            next_wake_mask_flag = reg_wdata[wake_mask_bit];
            next_irq_mask = reg_wdata[irq_request_bit];
        end

        // Enable write drags the wake masks along with it
        if (pm_control_status_write) begin
            next_pm_event_enable = pm_control_status_wdata[pm_enable_bit];
        end
        if (enable_write_one && bank_enable) begin
            next_general_wake_mask = 1'b1;
            next_wake_mask_flag = 1'b1;
        end

        // Clearing works even when bypassed, so the pin stays idle later
        if (enable_write_zero) begin
            next_general_wake_mask = 1'b0;
            next_wake_mask_flag = 1'b0;
        end
    end

    // -------------------------------------------------------------------
    // Event latch group
    // -------------------------------------------------------------------
    // Clears first, sets last: a wake arriving with a clear is not lost
    always_comb begin
        next_pm_event_status = pm_event_status;
        next_general_wake_flag = general_wake_flag;
        next_irq_request_flag = irq_request_flag;

        // Write-one-to-clear paths, cross-coupled between the two registers
        if (status_w1c) begin
            next_pm_event_status = 1'b0;
            next_general_wake_flag = 1'b0;
        end
        if (event_wake_w1c) begin
            next_general_wake_flag = 1'b0;
            next_pm_event_status = 1'b0;
        end
        if (event_irq_w1c) begin
            next_irq_request_flag = 1'b0;
        end

        // Set terms last so they win over a same-cycle clear
        if (wake_event) begin
            next_pm_event_status = 1'b1;
            next_general_wake_flag = 1'b1;
        end
        if (powerdown_request) begin
            next_irq_request_flag = 1'b1;
        end

        // Debug force sets the latches without touching present state
        if (force_wake) begin
            next_general_wake_flag = 1'b1;
        end
        if (force_irq) begin
            next_irq_request_flag = 1'b1;
        end
    end

    // -------------------------------------------------------------------
    // Pin group
    // -------------------------------------------------------------------
    logic bank_irq_active;
    logic bank_wake_active;
    logic bypass_wake_active;

    // Bank on: a latched request reaches a pin only through its mask
    assign bank_irq_active = irq_mask && irq_request_flag;
    assign bank_wake_active = general_wake_mask && wake_mask_flag
        && general_wake_flag;

    // Bypassed: the status bit drives the pin while enabled, as in PCI mode
    assign bypass_wake_active = pm_event_status && pm_event_enable;

    // Pins are registered from the latches, two cycles behind a request or a clear (one for the bypass irq pin);
    // the host side must not expect a same-cycle response to a request or a clear
    always_comb begin
        if (bank_enable) begin
            next_card_irq_pin_n = !bank_irq_active;
            next_card_status_change_pin = bank_wake_active;
        end else begin
            next_card_irq_pin_n = !powerdown_request;
            next_card_status_change_pin = bypass_wake_active;
        end
    end

    // -------------------------------------------------------------------
    // Read group
    // -------------------------------------------------------------------
    logic [reg_width-1:0] event_word;
    logic [reg_width-1:0] mask_word;
    logic [reg_width-1:0] present_word;

    // Register images; unlisted positions read zero
    always_comb begin
        // Event register: latched flags only, low four bits zero
        event_word = '0;
        event_word[general_wake_bit] = general_wake_flag;
        event_word[irq_request_bit] = irq_request_flag;

        // Mask register
        mask_word = '0;
        mask_word[general_wake_bit] = general_wake_mask;
        mask_word[wake_mask_bit] = wake_mask_flag;
        mask_word[irq_request_bit] = irq_mask;

        // Present state shows the raw requests, not the latches
        present_word = present_fixed;
        present_word[general_wake_bit] = wake_request;
        present_word[irq_request_bit] = powerdown_request;
    end

    // Read data is zero outside a read so a stale word never looks fresh
    always_comb begin
        next_reg_rdata = '0;
        if (rd_bank) begin
            unique case (reg_addr)
                event_latch_off: next_reg_rdata = event_word;
                event_mask_off: next_reg_rdata = mask_word;
                present_state_off: next_reg_rdata = present_word;
                default: next_reg_rdata = '0; // Force register has no storage
            endcase
        end
    end

    // -------------------------------------------------------------------
    // Registers
    // -------------------------------------------------------------------
    // One register process per group; each only copies its next values

    // Enable and mask group
    always_ff @(posedge mclk) begin
        if (rst) begin
            pm_event_enable <= 1'b0;
            general_wake_mask <= 1'b0;
            wake_mask_flag <= 1'b0;
            irq_mask <= 1'b0;
        end else begin
            pm_event_enable <= next_pm_event_enable;
            general_wake_mask <= next_general_wake_mask;
            wake_mask_flag <= next_wake_mask_flag;
            irq_mask <= next_irq_mask;
        end
    end

    // Event latch group
    always_ff @(posedge mclk) begin
        if (rst) begin
            pm_event_status <= 1'b0;
            general_wake_flag <= 1'b0;
            irq_request_flag <= 1'b0;
        end else begin
            pm_event_status <= next_pm_event_status;
            general_wake_flag <= next_general_wake_flag;
            irq_request_flag <= next_irq_request_flag;
        end
    end

    // Pin group; the irq pin resets to its inactive high level
    always_ff @(posedge mclk) begin
        if (rst) begin
            card_irq_pin_n <= 1'b1;
            card_status_change_pin <= 1'b0;
        end else begin
            card_irq_pin_n <= next_card_irq_pin_n;
            card_status_change_pin <= next_card_status_change_pin;
        end
    end

    // Read group
    always_ff @(posedge mclk) begin
        if (rst) begin
            reg_rdata <= '0;
        end else begin
            reg_rdata <= next_reg_rdata;
        end
    end

endmodule
`default_nettype wire

// file: dv/card_pm_event_gating_monitor.sv
`timescale 1ns/1ps
`default_nettype none
module card_pm_event_gating_monitor
    import card_pm_pkg::*;
(
    // Watched ports
    input wire logic mclk,
    input wire logic rst,
    input wire logic bank_enable,
    input wire logic wake_request,
    input wire logic powerdown_request,
    input wire logic pm_control_status_write,
    input wire logic [pm_control_status_width-1:0] pm_control_status_wdata,
    input wire logic pm_event_enable,
    input wire logic pm_event_status,
    input wire logic card_irq_pin_n,
    input wire logic card_status_change_pin
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (rst);
    // Reset must not be masked here, so the default disable is overridden
    AST_RESET: assert property (disable iff (1'b0) rst |=> !pm_event_enable &&
        !pm_event_status && card_irq_pin_n && !card_status_change_pin) else $error("reset state");
    AST_ENABLE: assert property (pm_control_status_write |=>
        pm_event_enable == $past(pm_control_status_wdata[pm_enable_bit])) else $error("enable bit");
    AST_STATUS_SET: assert property (pm_event_enable && wake_request |=>
        pm_event_status) else $error("wake not latched");
    AST_W1C: assert property (pm_control_status_write && pm_control_status_wdata[pm_status_bit] &&
        !(pm_event_enable && wake_request) |=> !pm_event_status) else $error("status clear");
    AST_HOLD: assert property (pm_event_status && !bank_enable && !pm_control_status_write |=>
        pm_event_status) else $error("status not sticky");
    AST_DISABLE_PIN: assert property (pm_control_status_write && !pm_control_status_wdata[pm_enable_bit] |=>
        ##1 !card_status_change_pin) else $error("wake pin after disable");
    AST_BYP_IRQ: assert property (!bank_enable |=>
        card_irq_pin_n == !$past(powerdown_request)) else $error("bypass irq pin");
    AST_BYP_WAKE: assert property (!bank_enable |=> card_status_change_pin ==
        ($past(pm_event_status) && $past(pm_event_enable))) else $error("bypass wake pin");
endmodule
`default_nettype wire

// file: dv/card_pm_event_gating_tb.sv
`timescale 1ns/1ps
`default_nettype none
module card_pm_event_gating_tb;
    import card_pm_pkg::*;
    logic mclk = 1'b0, rst = 1'b1, bank_enable = 1'b0, wake_request = 1'b0;
    logic powerdown_request = 1'b0, reg_write = 1'b0, reg_read = 1'b0, pm_control_status_write;
    logic pm_event_enable, pm_event_status, card_irq_pin_n, card_status_change_pin;
    logic [3:0] reg_addr = 4'h0;
    logic [31:0] reg_wdata = 32'h0, reg_rdata;
    logic [15:0] pm_control_status_wdata;
    int miscompares = 0, n_compared = 0;
    // Packed view: enable, status, irq pin, wake pin
    wire logic [31:0] state = {28'h0, pm_event_enable, pm_event_status,
        card_irq_pin_n, card_status_change_pin};
    always #5 mclk = ~mclk;
    card_pm_event_gating i_card_pm_event_gating (.*);
    card_pm_host i_card_pm_host (.*);
    task automatic cmp(input string what, input logic [31:0] exp, input logic [31:0] got);
        n_compared++;
        if (got !== exp) begin
            miscompares++;
            $display("unexpected %s: expected %h seen %h", what, exp, got);
        end
    endtask
    // Level input raised for one cycle, then time for the pins to follow
    task automatic pulse(ref logic s);
        s = 1'b1;
        @(negedge mclk);
        s = 1'b0;
        repeat (2) @(negedge mclk);
    endtask
    // Bank access; read data stands one cycle only, so it is compared at once
    task automatic acc(input logic w, input logic [3:0] a, input logic [31:0] d);
        {reg_write, reg_read, reg_addr, reg_wdata} = {w, !w, a, d};
        @(negedge mclk);
        {reg_write, reg_read} = 2'b00;
        if (!w) cmp("reg_rdata", d, reg_rdata);
        repeat (2) @(negedge mclk);
    endtask
    task automatic conclude();
        $display("compared %0d miscompares %0d", n_compared, miscompares);
        if (miscompares == 0 && n_compared > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    // Main sequence: bypass first, then the bank enabled
    initial begin
        repeat (16) @(negedge mclk);
        rst = 1'b0;
        cmp("state", 32'h2, state);
        powerdown_request = 1'b1;
        acc(1'b0, event_latch_off, 32'h0);
        cmp("state", 32'h0, state);
        powerdown_request = 1'b0;
        i_card_pm_host.pm_write(16'h0100);
        pulse(wake_request);
        cmp("state", 32'hf, state);
        i_card_pm_host.pm_write(16'h8100);
        cmp("state", 32'ha, state);
        bank_enable = 1'b1;
        acc(1'b1, event_latch_off, 32'h8010);
        i_card_pm_host.pm_write(16'h0100);
        acc(1'b0, event_mask_off, 32'h4010);
        pulse(powerdown_request);
        acc(1'b0, event_latch_off, 32'h8000);
        cmp("state", 32'ha, state);
        acc(1'b1, event_mask_off, 32'hc010);
        cmp("state", 32'h8, state);
        acc(1'b1, event_latch_off, 32'h8000);
        cmp("state", 32'ha, state);
        pulse(wake_request);
        cmp("state", 32'hf, state);
        i_card_pm_host.pm_write(16'h8100);
        acc(1'b0, event_latch_off, 32'h0);
        pulse(wake_request);
        acc(1'b1, event_latch_off, 32'h0010);
        cmp("state", 32'ha, state);
        acc(1'b1, event_mask_off, 32'h8000);
        cmp("state", 32'ha, state);
        i_card_pm_host.pm_write(16'h0000);
        acc(1'b0, event_mask_off, 32'h8000);
        pulse(wake_request);
        acc(1'b0, event_latch_off, 32'h0);
        acc(1'b0, present_state_off, 32'he);
        acc(1'b1, force_event_off, 32'h8010);
        acc(1'b0, event_latch_off, 32'h8010);
        cmp("state", 32'h0, state);
        rst = 1'b1;
        repeat (2) @(negedge mclk);
        rst = 1'b0;
        cmp("state", 32'h2, state);
        acc(1'b0, event_mask_off, 32'h0);
        acc(1'b1, event_mask_off, 32'hc010);
        bank_enable = 1'b0;
        acc(1'b0, event_mask_off, 32'h0);
        conclude();
    end
endmodule
bind card_pm_event_gating card_pm_event_gating_monitor i_card_pm_event_gating_monitor (.*);
`default_nettype wire

// file: dv/card_pm_host.sv
`timescale 1ns/1ps
`default_nettype none
module card_pm_host
(
    // Power management write port
    input wire logic mclk,
    output logic pm_control_status_write,
    output logic [15:0] pm_control_status_wdata
);
    initial {pm_control_status_write, pm_control_status_wdata} = 17'h0;
    // Data is inverted after release so a stale value never looks fresh
    task automatic pm_write(input logic [15:0] value);
        @(negedge mclk);
        {pm_control_status_write, pm_control_status_wdata} = {1'b1, value};
        @(negedge mclk);
        {pm_control_status_write, pm_control_status_wdata} = {1'b0, ~value};
        repeat (2) @(negedge mclk);
    endtask
endmodule
`default_nettype wire

// file: include/card_pm_pkg.sv
package card_pm_pkg;

    // -------------------------------------------------------------------
    // Status bank register map (byte offsets from the window base)
    // -------------------------------------------------------------------
    localparam logic [3:0] event_latch_off = 4'h0;
    localparam logic [3:0] event_mask_off = 4'h4;
    localparam logic [3:0] present_state_off = 4'h8;
    localparam logic [3:0] force_event_off = 4'hc;

    // -------------------------------------------------------------------
    // Field positions
    // -------------------------------------------------------------------
    localparam int general_wake_bit = 4;
    localparam int wake_mask_bit = 14;
    localparam int irq_request_bit = 15;
    localparam int pm_enable_bit = 8;
    localparam int pm_status_bit = 15;

    // Present state: ready and both battery detects read one, write protect zero
    localparam logic [31:0] present_fixed = 32'h0000_000e;

    localparam int reg_width = 32;
    localparam int pm_control_status_width = 16;

endpackage
